// *** src/fpt_pkg.sv ***
// fpt_pkg: constants and types for the flash protect / timing register block.
// assumes a 32-bit axi4-lite register bus, one register per aligned word.
package fpt_pkg;

  // ----------------------------------------------------------------
  // register map (word indices; the byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_IDX     = 12'hff8; // flash control register index
  localparam logic [11:0] GUARD_IDX    = 12'hff9; // shared page select / sector guard index
  localparam logic [11:0] TIM_HI_IDX   = 12'hffa; // timing value high byte index
  localparam logic [11:0] TIM_LO_IDX   = 12'hffb; // timing value low byte index
  localparam logic [11:0] GUARD_RD_IDX = 12'hffc; // read-back of guard bits
  localparam logic [11:0] STAT_IDX     = 12'hffd; // status word
  localparam int unsigned ADDR_W       = 16;

  // ----------------------------------------------------------------
  // values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  GUARD_UNLOCK = 8'h5e;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int unsigned SECTORS      = 8;
  localparam int unsigned HZ_PER_KHZ   = 1000;
  // sector size in bytes per variant
  localparam int unsigned SECT_LARGE   = 3072;
  localparam int unsigned SECT_MEDIUM  = 2048;
  localparam int unsigned SECT_SMALL   = 1024;

  typedef enum logic [1:0] {
    FPT_VAR_SMALL,
    FPT_VAR_MEDIUM,
    FPT_VAR_LARGE
  } fpt_variant_e;

  // write request as seen by the register file
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fpt_wreq_s;

endpackage : fpt_pkg

// *** src/fpt_regs.sv ***
// fpt_regs: axi4-lite register file with sector write guard and timing value.
// assumes a single-clock system; flash engine outside consumes guard and timing.
// Overview of operation
// - after control gets 5eh, the sector guard is loaded only if the very next write goes to the shared address
// - other shared-address writes load page select, guard bits untouched
// - guard holds eight bits, bit x protects sector x
// - all guard bits clear on reset
// - set guard bits stay set until system reset
// - sector size per bit follows variant: 3kb, 2kb or 1kb
// - timing value is high byte over low byte, sixteen bits
// - timing value drives program and erase duration derivation
`timescale 1ns/1ps
module fpt_regs #(
  parameter fpt_pkg::fpt_variant_e VARIANT = fpt_pkg::FPT_VAR_SMALL,
  parameter int unsigned           ADDR_W  = fpt_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address / data / response
  input  wire logic [ADDR_W-1:0]    s_awaddr,
  input  wire logic [2:0]           s_awprot,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  // axi4-lite read address / data
  input  wire logic [ADDR_W-1:0]    s_araddr,
  input  wire logic [2:0]           s_arprot,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  // flash engine side
  output logic [7:0]                sector_guard_bit,
  output logic [7:0]                page_select,
  output logic [15:0]               program_timing_value,
  output logic [15:0]               sector_bytes
);

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  logic                aw_full_q, w_full_q;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic [7:0]          w_byte_q;
  logic                w_lane0_q;
  logic                wr_fire;

  // address and data are taken in either order, held until the response
  assign s_awready = !aw_full_q && !s_bvalid;
  assign s_wready  = !w_full_q && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q  <= fpt_pkg::BYTE_RST;
      w_lane0_q <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_full_q  <= 1'b1;
        w_byte_q  <= s_wdata[7:0];
        w_lane0_q <= s_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic [11:0] wr_idx;
  logic        wr_hit_ctrl, wr_hit_guard, wr_hit_hi, wr_hit_lo, wr_mapped;
  fpt_pkg::fpt_wreq_s wreq;

  assign wr_fire      = aw_full_q && w_full_q;
  assign wreq         = '{addr: aw_addr_q, data: w_byte_q};
  assign wr_idx       = wreq.addr[13:2];
  assign wr_hit_ctrl  = wr_fire && w_lane0_q && (wr_idx == fpt_pkg::CTRL_IDX);
  assign wr_hit_guard = wr_fire && w_lane0_q && (wr_idx == fpt_pkg::GUARD_IDX);
  assign wr_hit_hi    = wr_fire && w_lane0_q && (wr_idx == fpt_pkg::TIM_HI_IDX);
  assign wr_hit_lo    = wr_fire && w_lane0_q && (wr_idx == fpt_pkg::TIM_LO_IDX);
  assign wr_mapped    = (wr_idx == fpt_pkg::CTRL_IDX) || (wr_idx == fpt_pkg::GUARD_IDX) ||
                        (wr_idx == fpt_pkg::TIM_HI_IDX) || (wr_idx == fpt_pkg::TIM_LO_IDX) ||
                        (wr_idx == fpt_pkg::GUARD_RD_IDX) || (wr_idx == fpt_pkg::STAT_IDX);

  // ----------------------------------------------------------------
  // control, unlock, guard, page select and timing registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic        unlock_q;
  logic [7:0]  guard_q, page_q, tim_hi_q, tim_lo_q;
  logic        to_guard;

  // unlock is armed only by the control write itself; any other write disarms it
  assign to_guard = wr_hit_guard && unlock_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= fpt_pkg::BYTE_RST;
      unlock_q <= 1'b0;
      guard_q  <= fpt_pkg::BYTE_RST;
      page_q   <= fpt_pkg::BYTE_RST;
      tim_hi_q <= fpt_pkg::BYTE_RST;
      tim_lo_q <= fpt_pkg::BYTE_RST;
    end else begin
      if (wr_hit_ctrl) begin
        ctrl_q <= wreq.data;
      end
      if (wr_fire) begin
        unlock_q <= wr_hit_ctrl && (wreq.data == fpt_pkg::GUARD_UNLOCK);
      end
      if (to_guard) begin
        guard_q <= guard_q | wreq.data;
      end
      if (wr_hit_guard && !unlock_q) begin
        page_q <= wreq.data;
      end
      if (wr_hit_hi) begin
        tim_hi_q <= wreq.data;
      end
      if (wr_hit_lo) begin
        tim_lo_q <= wreq.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  logic       bvalid_q;
  logic [1:0] bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= fpt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_bvalid = bvalid_q;
  assign s_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [11:0] rd_idx;
  logic [31:0] rd_word;
  logic        rd_mapped;

  assign s_arready = !rvalid_q;
  assign rd_idx    = s_araddr[13:2];

  // the shared address reads page select; guard bits have their own read-back word
  assign rd_mapped = wr_mapped_rd(rd_idx);
  assign rd_word =
    (rd_idx == fpt_pkg::CTRL_IDX)     ? {24'h000000, ctrl_q}   :
    (rd_idx == fpt_pkg::GUARD_IDX)    ? {24'h000000, page_q}   :
    (rd_idx == fpt_pkg::TIM_HI_IDX)   ? {24'h000000, tim_hi_q} :
    (rd_idx == fpt_pkg::TIM_LO_IDX)   ? {24'h000000, tim_lo_q} :
    (rd_idx == fpt_pkg::GUARD_RD_IDX) ? {24'h000000, guard_q}  :
    (rd_idx == fpt_pkg::STAT_IDX)     ? {31'h00000000, unlock_q} :
                                        32'h00000000;

  function automatic logic wr_mapped_rd(input logic [11:0] idx);
    wr_mapped_rd = (idx == fpt_pkg::CTRL_IDX) || (idx == fpt_pkg::GUARD_IDX) ||
                   (idx == fpt_pkg::TIM_HI_IDX) || (idx == fpt_pkg::TIM_LO_IDX) ||
                   (idx == fpt_pkg::GUARD_RD_IDX) || (idx == fpt_pkg::STAT_IDX);
  endfunction : wr_mapped_rd

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= fpt_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_mapped ? fpt_pkg::RESP_OKAY : fpt_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_rvalid = rvalid_q;
  assign s_rdata  = rdata_q;
  assign s_rresp  = rresp_q;

  // ----------------------------------------------------------------
  // outputs to the flash engine
  // ----------------------------------------------------------------
  assign sector_guard_bit     = guard_q;
  // engine derives program and erase durations from this kilohertz count
  assign program_timing_value = {tim_hi_q, tim_lo_q};
  assign sector_bytes =
    (VARIANT == fpt_pkg::FPT_VAR_LARGE)  ? 16'(fpt_pkg::SECT_LARGE)  :
    (VARIANT == fpt_pkg::FPT_VAR_MEDIUM) ? 16'(fpt_pkg::SECT_MEDIUM) :
                                           16'(fpt_pkg::SECT_SMALL);
  assign page_select          = page_q;

endmodule : fpt_regs

// *** testbench/fpt_regs_asserts.sv ***
// fpt_regs_asserts: port-level checks of the guard and timing register block.
// assumes it is bound onto fpt_regs; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module fpt_regs_asserts #(
  parameter fpt_pkg::fpt_variant_e VARIANT = fpt_pkg::FPT_VAR_SMALL
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes and answers
  input wire logic        s_awready,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  // flash engine side
  input wire logic [7:0]  sector_guard_bit,
  input wire logic [7:0]  page_select,
  input wire logic [15:0] program_timing_value,
  input wire logic [15:0] sector_bytes
);
  // ----------------------------------------------------------------
  // expected sector size and shared sequences
  // ----------------------------------------------------------------
  wire logic [15:0] exp_bytes;
  assign exp_bytes = (VARIANT == fpt_pkg::FPT_VAR_LARGE)  ? 16'h0c00 :
                     (VARIANT == fpt_pkg::FPT_VAR_MEDIUM) ? 16'h0800 : 16'h0400;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_req; s_arvalid && s_arready; endsequence
  sequence s_wr_done; $rose(s_bvalid); endsequence
  // past reset guard keeps a one-edge reset from looking like a register change
  rst_clear_a: assert property (disable iff (1'b0) !aresetn |=> sector_guard_bit == 8'h00
    && page_select == 8'h00 && program_timing_value == 16'h0000 && !s_bvalid)
    else $error("state not cleared by reset");
  guard_sticky_a: assert property (1'b1 |=> (sector_guard_bit & $past(sector_guard_bit))
    == $past(sector_guard_bit)) else $error("guard bit cleared");
  guard_on_wr_a: assert property ($past(aresetn) && !$stable(sector_guard_bit) |-> s_wr_done)
    else $error("guard changed without a write");
  page_on_wr_a: assert property ($past(aresetn) && !$stable(page_select) |-> s_wr_done)
    else $error("page select changed without a write");
  timing_on_wr_a: assert property ($past(aresetn) && !$stable(program_timing_value)
    |-> s_wr_done) else $error("timing value changed without a write");
  bytes_fixed_a: assert property (sector_bytes == exp_bytes)
    else $error("sector size wrong for variant");
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  busy_refuse_a: assert property ((s_bvalid |-> !s_awready && !s_wready) and
    (s_rvalid |-> !s_arready)) else $error("request accepted while answer pending");
  rd_answer_a: assert property (s_rd_req |=> s_rvalid) else $error("read not answered");
endmodule : fpt_regs_asserts

bind fpt_regs fpt_regs_asserts #(.VARIANT(VARIANT)) fpt_regs_asserts_inst (.aclk, .aresetn,
  .s_awready, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata,
  .s_rvalid, .s_rready, .sector_guard_bit, .page_select, .program_timing_value, .sector_bytes);

// *** testbench/fpt_regs_test.sv ***
// fpt_regs_test: self-checking bench for the guard and timing register block.
// assumes fpt_regs in its default variant; the bench is the only bus master.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH %0t got %h want %h", $time, (a), (b)); end end
module fpt_regs_test;
  // ----------------------------------------------------------------
  // addresses, stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [15:0] A_CTRL = {2'h0, fpt_pkg::CTRL_IDX, 2'h0};
  localparam logic [15:0] A_GRD  = {2'h0, fpt_pkg::GUARD_IDX, 2'h0};
  localparam logic [15:0] A_HI   = {2'h0, fpt_pkg::TIM_HI_IDX, 2'h0};
  localparam logic [15:0] A_LO   = {2'h0, fpt_pkg::TIM_LO_IDX, 2'h0};
  localparam logic [15:0] A_RB   = {2'h0, fpt_pkg::GUARD_RD_IDX, 2'h0};
  localparam logic [15:0] A_ST   = {2'h0, fpt_pkg::STAT_IDX, 2'h0};
  localparam logic [1:0]  OK     = fpt_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR    = fpt_pkg::RESP_SLVERR;
  localparam logic [7:0]  KEY    = fpt_pkg::GUARD_UNLOCK;
  // bench clock of 50 ns is 20 mhz, inside the supported band
  localparam int unsigned CLK_KHZ = 20_000_000 / fpt_pkg::HZ_PER_KHZ;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000, tval, sbytes;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic [7:0]  guard, page;
  int          failures = 0, cmp_count = 0;
  fpt_regs fpt_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awprot(3'h0),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arprot(3'h0), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready), .sector_guard_bit(guard), .page_select(page),
    .program_timing_value(tval), .sector_bytes(sbytes));
  always #25 aclk = ~aclk;
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // each channel released at its own handshake edge; a stuck slave ends the run
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin bready <= 1'b0; `CHK(bresp, r) end
    end while (n < 40 && (awvalid || wvalid || bready));
    if (n >= 40) begin failures++; complete_run(); end
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin rready <= 1'b0; `CHK({rresp, rdata}, {r, 24'h0, d}) end
    end while (n < 40 && (arvalid || rready));
    if (n >= 40) begin failures++; complete_run(); end
  endtask : rd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK({guard, page, tval}, 32'h0000_0000)
    `CHK(sbytes, 16'h0400)
    rd(A_RB, 8'h00, OK);
  endtask : t_reset
  task automatic t_guard();
    wr(A_GRD, 8'h37, 4'h1, OK);
    `CHK({guard, page}, 16'h0037)
    wr(A_CTRL, KEY, 4'h1, OK);
    rd(A_ST, 8'h01, OK);
    wr(A_GRD, 8'h05, 4'h1, OK);
    `CHK({guard, page}, 16'h0537)
    wr(A_CTRL, KEY, 4'h1, OK);
    wr(A_GRD, 8'h80, 4'h1, OK);
    `CHK(guard, 8'h85)
    wr(A_GRD, 8'h00, 4'h1, OK);
    `CHK({guard, page}, 16'h8500)
    wr(A_CTRL, KEY, 4'h1, OK);
    wr(A_GRD, 8'hff, 4'h0, OK);
    wr(A_GRD, 8'h02, 4'h1, OK);
    `CHK({guard, page}, 16'h8502)
    rd(A_RB, 8'h85, OK);
  endtask : t_guard
  task automatic t_timing();
    wr(A_HI, 8'h4e, 4'h1, OK);
    wr(A_LO, 8'h20, 4'h1, OK);
    `CHK(tval, 16'h4e20)
    `CHK(tval, 16'(CLK_KHZ))
    rd(A_HI, 8'h4e, OK);
  endtask : t_timing
  task automatic t_bad();
    wr(16'h0100, KEY, 4'h1, ERR);
    rd(16'h0100, 8'h00, ERR);
    wr(A_GRD, 8'h11, 4'h1, OK);
    `CHK({guard, page}, 16'h8511)
  endtask : t_bad
  // answers must stand while the master holds off bready and rready
  task automatic t_stall();
    int n;
    n = 0;
    awaddr <= A_GRD; wdata <= 32'h0000_006c; wstrb <= 4'h1; awvalid <= 1'b1; wvalid <= 1'b1;
    araddr <= A_HI; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (n < 40 && !(bvalid && rvalid));
    if (n >= 40) begin failures++; complete_run(); end
    repeat (3) @(posedge aclk);
    `CHK({bvalid, rvalid, awready, wready, arready}, 5'b11000)
    bready <= 1'b1; rready <= 1'b1;
    @(posedge aclk);
    `CHK({bvalid, bresp, rvalid, rresp, rdata}, {1'b1, OK, 1'b1, OK, 32'h0000_004e})
    `CHK({guard, page}, 16'h856c)
    bready <= 1'b0; rready <= 1'b0;
    @(posedge aclk);
  endtask : t_stall
  task automatic t_rst();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({guard, tval}, 24'h000000)
  endtask : t_rst
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_guard();
    t_timing();
    t_bad();
    t_stall();
    t_rst();
    complete_run();
  end
endmodule : fpt_regs_test
